/* File: logic/fai_pkg.sv */
// Constants and types shared by the fault alert interface
package fai_pkg;
	// System clock period and alert waveform timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int WAVE_HALF_NS  = 250;
	localparam int WAVE_HALF_CYC = WAVE_HALF_NS / CLK_PERIOD_NS;
	localparam int WAVE_PER_CYC  = 2 * WAVE_HALF_CYC;
	localparam int PER_TOL_CYC   = 2;
	// Incoming alert must stay valid this long
	localparam int QUAL_TIME_NS  = 25000;
	localparam int QUAL_CYC      =
		(QUAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Alert status word layout
	localparam int STAT_W  = 16;
	localparam int POR_BIT = 14;
	// Counter widths
	localparam int WCNT_W = 4;
	localparam int PER_W  = 6;
	// Link topology codes
	localparam logic [1:0] TOPO_EXT_LOOP = 2'h0;
	localparam logic [1:0] TOPO_INT_LOOP = 2'h1;
	localparam logic [1:0] TOPO_DIFF     = 2'h2;
	localparam logic [1:0] TOPO_DUAL     = 2'h3;
	// Single-bit selects
	localparam logic HPS_SPI  = 1'h0;
	localparam logic HPS_UART = 1'h1;
	localparam logic DRV_OD   = 1'h0;
	localparam logic DRV_CMOS = 1'h1;
	localparam logic IDLE_GND = 1'h0;
	// Output driver modes
	typedef enum logic [2:0] {
		OM_SPI_OD   = 3'b000,
		OM_SPI_CMOS = 3'b001,
		OM_UART_AC  = 3'b010,
		OM_UART_DC  = 3'b011,
		OM_DIFF     = 3'b100
	} fai_mode_e;
	// Incoming alert qualifier states
	typedef enum logic [1:0] {
		QS_HUNT  = 2'b00,
		QS_LOCK  = 2'b01,
		QS_ALERT = 2'b10
	} fai_qstate_e;
endpackage : fai_pkg

/* File: logic/fai_in_qual.sv */
// Frequency and duration qualifier for the incoming chain alert
`timescale 1ns/10ps
module fai_in_qual
	import fai_pkg::*;
#(
	parameter int PER_NOM_P  = WAVE_PER_CYC,
	parameter int PER_TOL_P  = PER_TOL_CYC,
	parameter int QUAL_CYC_P = QUAL_CYC,
	parameter int ACC_W      = $clog2(QUAL_CYC_P + 1)
)(
	input  wire logic clk_sys_i,
	input  wire logic rstn_i,
	input  wire logic enable_i,
	input  wire logic sync_i,
	output logic      qual_o
);
	localparam logic [PER_W-1:0] PER_MIN = PER_W'(PER_NOM_P - PER_TOL_P);
	localparam logic [PER_W-1:0] PER_MAX = PER_W'(PER_NOM_P + PER_TOL_P);
	localparam logic [PER_W-1:0] PER_ONE = PER_W'(1);
	localparam logic [PER_W-1:0] PER_SAT = '1;
	localparam logic [ACC_W-1:0] ACC_TOP = ACC_W'(QUAL_CYC_P);

	fai_qstate_e      state_ff;
	fai_qstate_e      nxt_state;
	logic             prev_ff;
	logic [PER_W-1:0] per_cnt_ff;
	logic [ACC_W-1:0] acc_ff;
	logic             qual_ff;
	logic [ACC_W:0]   since_hunt_ff;

	// Period measurement between rising edges
	wire rise_w    = sync_i & ~prev_ff;
	wire per_ok_w  = rise_w & (per_cnt_ff >= PER_MIN)
		& (per_cnt_ff <= PER_MAX);
	wire timeout_w = ~rise_w & (per_cnt_ff > PER_MAX);
	wire break_w   = (rise_w & ~per_ok_w) | timeout_w;

	// Lock after one good period, alert after the full valid time
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			QS_HUNT:  if (per_ok_w) nxt_state = QS_LOCK;
			QS_LOCK:
			begin
				if (break_w) nxt_state = QS_HUNT;
				else if (acc_ff == ACC_TOP) nxt_state = QS_ALERT;
			end
			QS_ALERT: if (break_w) nxt_state = QS_HUNT;
			default:  nxt_state = QS_HUNT;
		endcase
		if (!enable_i) nxt_state = QS_HUNT;
	end

	// Edge history and period counter
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			prev_ff    <= 1'b0;
			per_cnt_ff <= '1;
		end
		else
		begin
			prev_ff <= sync_i;
			if (rise_w) per_cnt_ff <= PER_ONE;
			else if (per_cnt_ff != PER_SAT)
				per_cnt_ff <= PER_W'(per_cnt_ff + 1'b1);
		end
	end

	// State, valid-time accumulator and qualified flag
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_ff <= QS_HUNT;
			acc_ff   <= '0;
			qual_ff  <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			qual_ff  <= (nxt_state == QS_ALERT);
			if (nxt_state != QS_LOCK) acc_ff <= '0;
			else acc_ff <= ACC_W'(acc_ff + 1'b1);
		end
	end

	assign qual_o = qual_ff;

	// Cycles since the qualifier last hunted, for checking only
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i) since_hunt_ff <= '0;
		else if (state_ff == QS_HUNT) since_hunt_ff <= '0;
		else if (~&since_hunt_ff)
			since_hunt_ff <= (ACC_W+1)'(since_hunt_ff + 1'b1);
	end

	a_qual_full_time: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		$rose(qual_ff) |-> (since_hunt_ff >= QUAL_CYC_P))
		else $error("alert qualified before the full valid time");

	a_bad_period_drop: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(state_ff != QS_HUNT && rise_w && !per_ok_w)
		|=> (state_ff == QS_HUNT && !qual_ff))
		else $error("off-frequency period kept the lock");

	a_qual_off_dis: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		!enable_i |=> !qual_ff)
		else $error("qualifier active while disabled");
endmodule : fai_in_qual

/* File: logic/fai_top.sv */
// Fault alert combiner, output driver and chain input path
`timescale 1ns/10ps
module fai_top
	import fai_pkg::*;
#(
	parameter int STAT_W_P    = STAT_W,
	parameter int POR_BIT_P   = POR_BIT,
	parameter int WAVE_HALF_P = WAVE_HALF_CYC,
	parameter int PER_TOL_P   = PER_TOL_CYC,
	parameter int QUAL_CYC_P  = QUAL_CYC
)(
	input  wire logic                clk_sys_i,
	input  wire logic                rstn_i,
	input  wire logic [STAT_W_P-1:0] alert_status_reg_i,
	input  wire logic [STAT_W_P-1:0] alert_enable_i,
	input  wire logic                user_alert_force_i,
	input  wire logic                host_port_select_i,
	input  wire logic [1:0]          link_topology_cfg_i,
	input  wire logic                fault_iface_enable_i,
	input  wire logic                dc_alert_test_mode_i,
	input  wire logic                spi_drive_type_i,
	input  wire logic                idle_float_select_i,
	input  wire logic                scan_refresh_i,
	input  wire logic                fault_input_pin_i,
	output logic                     rx_positive_input_o,
	output logic                     fault_output_pin_o,
	output logic                     fault_output_pin_oe_o,
	output logic                     diff_alert_o,
	output logic                     alert_summary_o,
	output logic                     chain_alert_o
);
	localparam logic [WCNT_W-1:0] WAVE_TOP = WCNT_W'(WAVE_HALF_P - 1);
	localparam logic [WCNT_W:0]   HI_SAT   = '1;

	fai_mode_e         mode;
	logic              pin_meta_ff;
	logic              pin_sync_ff;
	logic              alert_ff;
	logic              nxt_alert;
	logic              wave_alert_ff;
	logic              nxt_wave_alert;
	logic [WCNT_W-1:0] wave_cnt_ff;
	logic [WCNT_W-1:0] nxt_wave_cnt;
	logic              phase_ff;
	logic              nxt_phase;
	logic              pin_out_ff;
	logic              nxt_pin_out;
	logic              pin_oe_ff;
	logic              nxt_pin_oe;
	logic              diff_ff;
	logic              nxt_diff;
	logic              chain_qual;
	logic [WCNT_W:0]   hi_len_ff;

	// Receiver positive input held at ground
	assign rx_positive_input_o = 1'b0;

	// Fault input pin synchroniser
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pin_meta_ff <= 1'b0;
			pin_sync_ff <= 1'b0;
		end
		else
		begin
			pin_meta_ff <= fault_input_pin_i;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	// Local alert: masked status, unmaskable reset flag, user force
	wire [STAT_W_P-1:0] masked_w = alert_status_reg_i
		& alert_enable_i;
	wire por_w   = alert_status_reg_i[POR_BIT_P];
	wire local_w = (|masked_w) | por_w
		| user_alert_force_i;

	// Single-ended path on only when enabled and not in the differential topology, unless DC test mode is set
	wire is_uart_w = (host_port_select_i == HPS_UART);
	wire diff_topo_w = (link_topology_cfg_i == TOPO_DIFF);
	wire se_on_w = fault_iface_enable_i
		& (~diff_topo_w | dc_alert_test_mode_i);
	// Chain input listened to only in UART with the path on
	wire chain_en_w = is_uart_w & se_on_w;

	// Output driver mode selection
	assign mode = !is_uart_w
		? ((spi_drive_type_i == DRV_CMOS) ? OM_SPI_CMOS
			: OM_SPI_OD)
		: dc_alert_test_mode_i ? OM_UART_DC
		: diff_topo_w ? OM_DIFF : OM_UART_AC;

	// Qualifier for the alert of the device below
	fai_in_qual #(
		.PER_NOM_P  (2 * WAVE_HALF_P),
		.PER_TOL_P  (PER_TOL_P),
		.QUAL_CYC_P (QUAL_CYC_P)
	) u_in_qual (
		.clk_sys_i (clk_sys_i),
		.rstn_i    (rstn_i),
		.enable_i  (chain_en_w),
		.sync_i    (pin_sync_ff),
		.qual_o    (chain_qual)
	);

	// Combined alert; chain alert only passes when qualified
	assign nxt_alert = local_w | (chain_qual & chain_en_w);

	// Waveform state refreshed on each scan tick, cleared at once
	assign nxt_wave_alert = scan_refresh_i ? alert_ff
		: (wave_alert_ff & alert_ff);

	// Square wave runs while the held alert lasts in AC modes
	wire ac_mode_w = (mode == OM_UART_AC) | (mode == OM_DIFF);
	wire en_run_w  = fault_iface_enable_i & ac_mode_w;
	wire run_w     = en_run_w & wave_alert_ff;
	wire wrap_w    = (wave_cnt_ff == WAVE_TOP);

	// Divider toggling the phase every half period
	always_comb
	begin
		nxt_wave_cnt = '0;
		nxt_phase    = 1'b0;
		if (run_w)
		begin
			nxt_wave_cnt = wrap_w ? '0
				: WCNT_W'(wave_cnt_ff + 1'b1);
			nxt_phase = wrap_w ? ~phase_ff : phase_ff;
		end
	end

	// Pin drive and enable per mode
	always_comb
	begin
		nxt_pin_out = 1'b0;
		nxt_pin_oe  = 1'b0;
		nxt_diff    = 1'b0;
		unique case (mode)
			OM_SPI_OD:
			begin
				nxt_pin_out = 1'b0;
				nxt_pin_oe  = fault_iface_enable_i & alert_ff;
			end
			OM_SPI_CMOS:
			begin
				nxt_pin_out = ~(fault_iface_enable_i & alert_ff);
				nxt_pin_oe  = 1'b1;
			end
			OM_UART_DC:
			begin
				nxt_pin_out = ~(fault_iface_enable_i & alert_ff);
				nxt_pin_oe  = 1'b1;
			end
			OM_UART_AC:
			begin
				if (run_w)
				begin
					nxt_pin_out = nxt_phase;
					nxt_pin_oe  = 1'b1;
				end
				else
				begin
					nxt_pin_out = 1'b0;
					nxt_pin_oe  = (idle_float_select_i == IDLE_GND);
				end
			end
			OM_DIFF:
			begin
				nxt_pin_out = 1'b0;
				nxt_pin_oe  = (idle_float_select_i == IDLE_GND);
				nxt_diff    = run_w & nxt_phase;
			end
			default:
			begin
				nxt_pin_out = 1'b0;
				nxt_pin_oe  = 1'b0;
			end
		endcase
	end

	// Alert and waveform registers
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			alert_ff      <= 1'b0;
			wave_alert_ff <= 1'b0;
			wave_cnt_ff   <= '0;
			phase_ff      <= 1'b0;
		end
		else
		begin
			alert_ff      <= nxt_alert;
			wave_alert_ff <= nxt_wave_alert;
			wave_cnt_ff   <= nxt_wave_cnt;
			phase_ff      <= nxt_phase;
		end
	end

	// Output registers
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pin_out_ff <= 1'b0;
			pin_oe_ff  <= 1'b0;
			diff_ff    <= 1'b0;
		end
		else
		begin
			pin_out_ff <= nxt_pin_out;
			pin_oe_ff  <= nxt_pin_oe;
			diff_ff    <= nxt_diff;
		end
	end

	// Summary keeps the local alert whatever the interface enable; the chain part needs it
	assign alert_summary_o       = alert_ff;
	assign chain_alert_o         = chain_qual;
	assign fault_output_pin_o    = pin_out_ff;
	assign fault_output_pin_oe_o = pin_oe_ff;
	assign diff_alert_o          = diff_ff;

	// High-phase length, for checking only
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i) hi_len_ff <= '0;
		else if (!phase_ff) hi_len_ff <= '0;
		else if (hi_len_ff != HI_SAT)
			hi_len_ff <= (WCNT_W+1)'(hi_len_ff + 1'b1);
	end

	a_mask_gates: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		((alert_status_reg_i & alert_enable_i) == '0 && !por_w
			&& !user_alert_force_i && !chain_qual) |=> !alert_ff)
		else $error("alert set with every source masked");

	a_por_unmask: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(por_w && alert_enable_i == '0) |=> alert_ff)
		else $error("reset flag did not raise the alert");

	a_force_alert: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(user_alert_force_i && !is_uart_w && fault_iface_enable_i)
		##1 (user_alert_force_i && !is_uart_w
			&& fault_iface_enable_i) |=> !pin_out_ff)
		else $error("forced alert did not pull the pin low");

	a_spi_od_drive: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(mode == OM_SPI_OD) |=> !pin_out_ff
			&& (pin_oe_ff == $past(fault_iface_enable_i && alert_ff)))
		else $error("open-drain pin drive wrong");

	a_spi_cmos_idle: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(mode == OM_SPI_CMOS && !nxt_alert) ##1 (mode == OM_SPI_CMOS)
		|=> pin_oe_ff && pin_out_ff)
		else $error("CMOS pin not high without alert");

	a_chain_ignored: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(!is_uart_w)[*2] |-> !chain_alert_o)
		else $error("chain alert seen in SPI configuration");

	a_disable_quiet: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(!fault_iface_enable_i)[*3]
		|-> !(pin_oe_ff && !pin_out_ff && !is_uart_w && !$past(is_uart_w))
			&& !diff_ff && (hi_len_ff == '0) && !phase_ff)
		else $error("alert sent with interface disabled");

	a_uart_wave_drv: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(mode == OM_UART_AC && run_w) |=> pin_oe_ff)
		else $error("UART wave not driven on the pin");

	a_diff_chain_off: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(diff_topo_w && !dc_alert_test_mode_i)[*2] |-> !chain_alert_o)
		else $error("chain alert kept in differential topology");

	a_summary_unmasked: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(!fault_iface_enable_i && local_w) |=> alert_summary_o)
		else $error("summary lost with the interface disabled");

	a_diff_idle: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(mode == OM_DIFF) |=> !pin_out_ff
			&& (pin_oe_ff == $past(idle_float_select_i == IDLE_GND)))
		else $error("single-ended alert active in differential mode");

	a_uart_idle: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(mode == OM_UART_AC && !run_w) |=> !pin_out_ff
			&& (pin_oe_ff == $past(idle_float_select_i == IDLE_GND)))
		else $error("UART idle drive wrong");

	a_dc_level: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(mode == OM_UART_DC && fault_iface_enable_i)
		|=> pin_oe_ff && (pin_out_ff == !$past(alert_ff)))
		else $error("DC test level wrong");

	a_wave_half: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		($fell(phase_ff) && $past(run_w) && $past(run_w, 2))
		|-> ($past(hi_len_ff) == (WCNT_W+1)'(WAVE_HALF_P - 1)))
		else $error("square wave half period wrong");

	a_wave_refresh: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(!wave_alert_ff && !scan_refresh_i) |=> !wave_alert_ff)
		else $error("waveform state changed without a scan tick");
endmodule : fai_top

/* File: bench/fai_far_model.sv */
// Far-side model: host pullup on the fault output, neighbour alert source
`timescale 1ns/10ps
module fai_far_model
(
	input  wire logic       clk_sys_i,
	input  wire logic       rstn_i,
	input  wire logic       pin_out_i,
	input  wire logic       pin_oe_i,
	input  wire logic       send_i,
	input  wire logic [4:0] half_i,
	output logic            pin_lvl_o,
	output logic            nb_line_o
);
	logic [4:0] cnt_ff;

	// Released pin is pulled high by the external resistor
	assign pin_lvl_o = pin_oe_i ? pin_out_i : 1'h1;

	// Neighbour sends a square wave of the chosen half period, else low
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cnt_ff    <= 5'h00;
			nb_line_o <= 1'h0;
		end
		else if (!send_i)
		begin
			cnt_ff    <= 5'h00;
			nb_line_o <= 1'h0;
		end
		else if (cnt_ff == half_i - 5'h01)
		begin
			cnt_ff    <= 5'h00;
			nb_line_o <= !nb_line_o;
		end
		else
			cnt_ff <= cnt_ff + 5'h01;
	end
endmodule : fai_far_model

/* File: bench/fai_top_tb.sv */
// Self-checking bench for the fault alert combiner and pin driver
`timescale 1ns/10ps
module fai_top_tb
	import fai_pkg::*;
;
	localparam int         QUAL    = 40;
	localparam logic [5:0] CH_HPS  = 6'h37;
	localparam logic [5:0] CH_EN   = 6'h2F;
	localparam logic [5:0] CH_EXP  = 6'h01;
	localparam logic [5:0] CH_DIFF = 6'h20;
	localparam logic [5:0] CH_OFF  = 6'h04;
	logic        clk_sys_i = 1'h0;
	logic        rstn_i    = 1'h0;
	logic [15:0] stat      = 16'h0000;
	logic [15:0] msk       = 16'h0000;
	logic        frc = 1'h0, hps = 1'h0, ifen = 1'h0, dct = 1'h0;
	logic        drv = 1'h0, idlef = 1'h0, refr = 1'h0, send = 1'h0;
	logic [1:0]  topo      = 2'h0;
	logic [4:0]  half      = 5'h0A;
	logic        rx_positive_input, pout, poe, diff, summ, chain, lvl, nb;
	int          n_fail = 0, num_checks = 0, cyc = 0;

	// Clock at 40 MHz
	always #12.5 clk_sys_i = !clk_sys_i;

	fai_top #(.QUAL_CYC_P(QUAL)) u_dut (
		.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.alert_status_reg_i(stat), .alert_enable_i(msk),
		.user_alert_force_i(frc), .host_port_select_i(hps),
		.link_topology_cfg_i(topo), .fault_iface_enable_i(ifen),
		.dc_alert_test_mode_i(dct), .spi_drive_type_i(drv),
		.idle_float_select_i(idlef), .scan_refresh_i(refr),
		.fault_input_pin_i(nb), .rx_positive_input_o(rx_positive_input),
		.fault_output_pin_o(pout), .fault_output_pin_oe_o(poe),
		.diff_alert_o(diff), .alert_summary_o(summ),
		.chain_alert_o(chain));

	fai_far_model u_far (
		.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .pin_out_i(pout),
		.pin_oe_i(poe), .send_i(send), .half_i(half),
		.pin_lvl_o(lvl), .nb_line_o(nb));

	// Verdict and end of run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	// Hang guard
	always @(posedge clk_sys_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			end_of_test();
		end
	end

	task automatic chk(input string nm, input logic [7:0] exp, got);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : tick

	// Counts level changes and high cycles over 80 cycles of a wave
	task automatic meas(input logic sel, output int tg, output int hi);
		logic prv, cur;
		tg = 0;
		hi = 0;
		@(negedge clk_sys_i);
		prv = sel ? diff : pout;
		repeat (80)
		begin
			hi += (prv === 1'h1);
			@(negedge clk_sys_i);
			cur = sel ? diff : pout;
			tg += (cur !== prv);
			prv = cur;
		end
	endtask : meas

	function automatic logic exp_alert(logic [15:0] s, e, logic f);
		return |(s & e) | s[POR_BIT] | f;
	endfunction : exp_alert

	// Main sequence
	initial
	begin
		int tg, hi;
		logic a, rf, rd, re, seen, dt;
		logic [15:0] rs, rm;
		void'($urandom(32528));
		repeat (8) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk("oe_in_reset", 1'h0, poe);
		chk("rx_positive", 1'h0, rx_positive_input);
		@(posedge clk_sys_i);
		rstn_i <= 1'h1;
		// SPI: random status, masks, force and driver type
		for (int i = 0; i < 40; i++)
		begin
			rs = (i == 0) ? 16'h4000 : 16'($urandom & $urandom & $urandom);
			rm = (i == 0) ? 16'h0000 : 16'($urandom);
			rf = ($urandom_range(3) == 0);
			rd = $urandom_range(1);
			re = (i == 0) ? 1'h1 : 1'($urandom_range(1));
			a = exp_alert(rs, rm, rf);
			@(posedge clk_sys_i);
			stat <= rs;
			msk <= rm;
			frc <= rf;
			drv <= rd;
			ifen <= re;
			tick(3);
			@(negedge clk_sys_i);
			chk("summary", a, summ);
			chk("spi_oe", rd ? 1'h1 : (re & a), poe);
			chk("spi_out", rd ? !(re & a) : 1'h0, pout);
			chk("spi_level", !(re & a), lvl);
		end
		// UART: every topology with both idle selects
		for (int k = 0; k < 8; k++)
		begin
			dt = (k[1:0] == TOPO_DIFF);
			@(posedge clk_sys_i);
			hps <= HPS_UART;
			ifen <= 1'h1;
			stat <= 16'h0000;
			frc <= 1'h1;
			topo <= k[1:0];
			idlef <= k[2];
			tick(3);
			refr <= 1'h1;
			@(posedge clk_sys_i);
			refr <= 1'h0;
			tick(4);
			meas(1'h0, tg, hi);
			chk("pin_toggles", dt ? 8'h00 : 8'h08, tg);
			chk("pin_high", dt ? 8'h00 : 8'h28, hi);
			chk("wave_oe", dt ? !k[2] : 1'h1, poe);
			meas(1'h1, tg, hi);
			chk("diff_toggles", dt ? 8'h08 : 8'h00, tg);
			chk("diff_high", dt ? 8'h28 : 8'h00, hi);
			@(posedge clk_sys_i);
			frc <= 1'h0;
			tick(4);
			@(negedge clk_sys_i);
			chk("idle_out", 1'h0, pout);
			chk("idle_oe", !k[2], poe);
			@(posedge clk_sys_i);
			frc <= 1'h1;
			tick(4);
			meas(1'h0, tg, hi);
			chk("no_refresh", 8'h00, tg);
		end
		// DC test level, also under the differential topology
		@(posedge clk_sys_i);
		dct <= 1'h1;
		topo <= TOPO_DIFF;
		tick(3);
		@(negedge clk_sys_i);
		chk("dc_out_alert", 1'h0, pout);
		chk("dc_oe", 1'h1, poe);
		@(posedge clk_sys_i);
		frc <= 1'h0;
		tick(3);
		@(negedge clk_sys_i);
		chk("dc_out_idle", 1'h1, pout);
		@(posedge clk_sys_i);
		dct <= 1'h0;
		// Chain input: good, short, off-frequency, SPI, disabled, topology 2
		for (int c = 0; c < 6; c++)
		begin
			@(posedge clk_sys_i);
			hps <= CH_HPS[c];
			ifen <= CH_EN[c];
			topo <= CH_DIFF[c] ? TOPO_DIFF : TOPO_EXT_LOOP;
			half <= CH_OFF[c] ? 5'h05 : 5'h0A;
			send <= 1'h1;
			seen = 1'h0;
			repeat ((c == 1) ? 35 : 200)
			begin
				@(negedge clk_sys_i);
				seen = seen | chain;
			end
			@(posedge clk_sys_i);
			send <= 1'h0;
			repeat (40) @(negedge clk_sys_i);
			chk("chain_seen", CH_EXP[c], seen);
			chk("chain_idle", 1'h0, chain);
		end
		end_of_test();
	end
endmodule : fai_top_tb
